// ---- logic/eptc_pkg.sv ----
// Shared constants and types for the panel timing and status command block
package eptc_pkg;
	// Command codes
	localparam logic [7:0] CMD_PANEL_CHECK = 8'h44;
	localparam logic [7:0] CMD_VCOM_INTERVAL = 8'h50;
	localparam logic [7:0] CMD_LOW_SUPPLY = 8'h51;
	localparam logic [7:0] CMD_NONOVERLAP = 8'h60;
	localparam logic [7:0] CMD_RESOLUTION = 8'h61;
	localparam logic [7:0] CMD_START_LINE = 8'h65;
	localparam logic [7:0] CMD_REVISION = 8'h70;
	localparam logic [7:0] CMD_STATUS = 8'h71;

	// Reset values
	localparam logic [7:0] VCOM_INTERVAL_RST = 8'hd7;
	localparam logic [7:0] NONOVERLAP_RST = 8'h22;
	localparam logic [23:0] RESOLUTION_RST = 24'h000000;
	localparam logic [23:0] START_LINE_RST = 24'h000000;

	// Field positions
	localparam int INTERVAL_LSB = 0;
	localparam int POL_LSB = 4;
	localparam int BORDER_LSB = 6;
	localparam int SGAP_LSB = 4;
	localparam int GGAP_LSB = 0;
	localparam int HRZ_LSB = 19;
	localparam int SSTART_LSB = 19;
	localparam int GSCAN_BIT = 12;

	// Timing figures
	localparam logic [4:0] INTERVAL_BASE_LINES = 5'h11;
	localparam logic [5:0] BLANKING_LINES = 6'h14;
	localparam logic [6:0] NONOVL_STEP = 7'h04;
	localparam int CLK_MHZ = 100;
	localparam int SUP_BUSY_US = 170;
	localparam int SUP_WINDOW_US = 500;
	localparam int SUP_BUSY_CYC = SUP_BUSY_US * CLK_MHZ;
	localparam int SUP_WINDOW_CYC = SUP_WINDOW_US * CLK_MHZ;

	// Waveform-table revision locations per bank
	localparam logic [12:0] OTP_BANK0_REV_ADDR = 13'h0aed;
	localparam logic [12:0] OTP_BANK1_REV_ADDR = 13'h16ed;

	// Identity nibbles, values arbitrary
	localparam logic [3:0] VENDOR_CODE = 4'h5;
	localparam logic [3:0] SILICON_REVISION = 4'h1;

	typedef enum logic [2:0] {
		TBL_FLOAT = 3'b000,
		TBL_RED = 3'b001,
		TBL_WHITE = 3'b010,
		TBL_BLACK = 3'b011,
		TBL_BLACK_TO_WHITE = 3'b100,
		TBL_WHITE_TO_BLACK = 3'b101,
		TBL_WHITE_HOLD = 3'b110,
		TBL_BLACK_HOLD = 3'b111
	} eptc_table_t;

	typedef enum logic [1:0] {
		SUP_IDLE = 2'b00,
		SUP_BUSY = 2'b01,
		SUP_HOLD = 2'b10
	} eptc_sup_state_t;
endpackage : eptc_pkg

// ---- logic/eptc_serial_port.sv ----
// Serial byte engine for the 4-wire command port
`timescale 1ns/1ps
`default_nettype none
module eptc_serial_port (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_csb,
	input wire logic i_scl,
	input wire logic i_sda_in,
	input wire logic i_dc,
	input wire logic i_tx_en,
	input wire logic i_tx_load,
	input wire logic [7:0] i_tx_byte,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_rx_dc,
	output logic o_sda_out,
	output logic o_sda_oe_b
);
	typedef struct packed {
		logic [1:0] csb_s;
		logic [2:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] dc_s;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic rx_dc;
		logic [7:0] tx;
		logic sda_out;
		logic oe_b;
	} eptc_serial_state_t;

	eptc_serial_state_t s_q;
	eptc_serial_state_t s_d;
	logic scl_rise;
	logic scl_fall;

	always_comb begin
		s_d = s_q;
		s_d.csb_s = {s_q.csb_s[0], i_csb};
		s_d.scl_s = {s_q.scl_s[1:0], i_scl};
		s_d.sda_s = {s_q.sda_s[0], i_sda_in};
		s_d.dc_s = {s_q.dc_s[0], i_dc};
		// Edges seen only on the second stage, the first stage feeds nothing else
		scl_rise = s_q.scl_s[1] & ~s_q.scl_s[2];
		scl_fall = ~s_q.scl_s[1] & s_q.scl_s[2];
		s_d.rx_valid = 1'b0;
		if (s_q.csb_s[1]) begin
			s_d.bit_cnt = 3'h0;
		end else if (scl_rise) begin
			s_d.shift = {s_q.shift[6:0], s_q.sda_s[1]};
			s_d.bit_cnt = s_q.bit_cnt + 3'h1;
			if (s_q.bit_cnt == 3'h7) begin // [RL23]
				s_d.rx_valid = 1'b1;
				s_d.rx_byte = {s_q.shift[6:0], s_q.sda_s[1]};
				s_d.rx_dc = s_q.dc_s[1];
			end
		end else if (scl_fall && s_q.bit_cnt != 3'h0) begin
			// Falling edge after the last bit keeps the fresh byte's MSB on the line
			s_d.tx = {s_q.tx[6:0], 1'b0};
		end
		if (i_tx_load) begin
			s_d.tx = i_tx_byte;
		end
		s_d.sda_out = s_d.tx[7];
		s_d.oe_b = ~(i_tx_en & ~s_q.csb_s[1] & s_q.dc_s[1]); // [RL23]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '{csb_s: 2'h3, scl_s: 3'h0, sda_s: 2'h0, dc_s: 2'h0, bit_cnt: 3'h0, shift: 8'h00,
				rx_valid: 1'b0, rx_byte: 8'h00, rx_dc: 1'b0, tx: 8'h00, sda_out: 1'b0, oe_b: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rx_valid = s_q.rx_valid;
	assign o_rx_byte = s_q.rx_byte;
	assign o_rx_dc = s_q.rx_dc;
	assign o_sda_out = s_q.sda_out;
	assign o_sda_oe_b = s_q.oe_b;
endmodule : eptc_serial_port
`default_nettype wire

// ---- logic/eptc_panel_timing.sv ----
// Panel timing configuration, waveform-table selection and status readout
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [RL1] Interval code gives 17 minus code lines
// [RL2] Vertical blanking stays twenty lines total; code sets front porch 0 when back porch exceeds 20
// [RL3] Three-colour border code picks table by polarity
// [RL4] Two-colour border: floating or transition table
// [RL5] Border level follows table level codes
// [RL6] Upper polarity for red, lower for data
// [RL7] Red polarity 0: red bit selects red
// [RL8] Red polarity 1: clear red bit selects red
// [RL9] Old/new pair picks one of four tables
// [RL10] New-data only mode maps single bit
// [RL11] Low-supply read returns flag in bit 0
// [RL12] Low-supply check holds busy 170 us
// [RL13] Host sends checks only while idle
// [RL14] Non-overlap gap is four times code+1
// [RL15] Resolution from five and nine bit fields
// [RL16] Last gate and source from resolution
// [RL17] Start lines set; source start multiple eight
// [RL18] Gate-scan bit selects cascade scanning
// [RL19] Revision read: table revision then identity
// [RL20] Status read returns seven flag bits
// [RL21] Panel check result: 0 fail, 1 pass
// [RL22] Status read accepted even while busy
// [RL23] Code byte with select low, then parameters
// [RL24] Settings reset to defaults, apply next frame
module eptc_panel_timing #(
	parameter int SUP_BUSY_CYC = eptc_pkg::SUP_BUSY_CYC,
	parameter int SUP_WINDOW_CYC = eptc_pkg::SUP_WINDOW_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_csb,
	input wire logic i_scl,
	input wire logic i_sda_in,
	input wire logic i_dc,
	output logic o_sda_out,
	output logic o_sda_oe_b,
	output logic o_busy_b,
	input wire logic i_frame_start,
	input wire logic i_two_colour_select,
	input wire logic [5:0] i_back_porch_lines,
	input wire logic i_pixel_valid,
	input wire logic i_new_frame_data,
	input wire logic i_old_frame_data,
	output eptc_pkg::eptc_table_t o_pixel_table,
	output logic o_pixel_table_valid,
	input wire logic [1:0] i_border_level_code,
	output eptc_pkg::eptc_table_t o_border_table,
	output logic [1:0] o_border_level,
	output logic o_border_drive,
	output logic [4:0] o_vcom_data_lines,
	output logic [5:0] o_front_porch_lines,
	output logic [6:0] o_source_to_gate_gap,
	output logic [6:0] o_gate_to_source_gap,
	output logic [7:0] o_first_source,
	output logic [7:0] o_last_source,
	output logic [8:0] o_first_gate,
	output logic [8:0] o_last_gate,
	output logic o_gate_scan_cascade,
	input wire logic i_low_supply_flag,
	input wire logic i_panel_check_result,
	output logic o_panel_check_en,
	input wire logic i_otp_bank_sel,
	output logic [12:0] o_otp_rev_addr,
	input wire logic [15:0] i_waveform_table_revision,
	input wire logic i_partial_mode_flag,
	input wire logic i_sensor_link_err,
	input wire logic i_sensor_link_busy_n,
	input wire logic i_frame_received,
	input wire logic i_power_on_state,
	input wire logic i_power_off_state,
	input wire logic i_drv_busy_b
);
	typedef struct packed {
		logic [1:0] sup_sync;
		logic [1:0] chk_sync;
		logic cmd_ok;
		logic [7:0] cmd;
		logic [1:0] idx;
		logic [7:0] vcom_interval;
		logic [7:0] nonoverlap;
		logic [23:0] resolution;
		logic [23:0] start_line;
		logic [7:0] applied_cfg;
		eptc_pkg::eptc_sup_state_t sup_st;
		logic [15:0] sup_cnt;
		logic low_supply;
		logic panel_ok;
		logic [7:0] tx_byte;
		logic tx_load;
		logic tx_en;
		logic busy_b;
		logic panel_check_en;
		eptc_pkg::eptc_table_t pixel_table;
		logic pixel_valid;
		eptc_pkg::eptc_table_t border_table;
		logic [1:0] border_level;
		logic border_drive;
		logic [4:0] vcom_lines;
		logic [5:0] front_porch;
		logic [6:0] sgap;
		logic [6:0] ggap;
		logic [7:0] first_src;
		logic [7:0] last_src;
		logic [8:0] first_gate;
		logic [8:0] last_gate;
		logic cascade;
		logic [12:0] otp_addr;
	} eptc_main_state_t;

	eptc_main_state_t s;
	eptc_main_state_t n;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic rx_dc;
	logic busy_now;
	logic [7:0] flags_byte;

	function automatic logic is_read(input logic [7:0] cmd);
		return cmd == eptc_pkg::CMD_PANEL_CHECK || cmd == eptc_pkg::CMD_LOW_SUPPLY ||
			cmd == eptc_pkg::CMD_REVISION || cmd == eptc_pkg::CMD_STATUS;
	endfunction : is_read

	function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic [1:0] idx, input logic low,
			input logic pok, input logic [7:0] flags);
		case (cmd)
			eptc_pkg::CMD_LOW_SUPPLY: read_byte = {7'h00, low}; // [RL11]
			eptc_pkg::CMD_PANEL_CHECK: read_byte = {7'h00, pok}; // [RL21]
			eptc_pkg::CMD_STATUS: read_byte = flags; // [RL20]
			eptc_pkg::CMD_REVISION: begin // [RL19]
				case (idx)
					2'h0: read_byte = i_waveform_table_revision[7:0];
					2'h1: read_byte = i_waveform_table_revision[15:8];
					default: read_byte = {eptc_pkg::VENDOR_CODE, eptc_pkg::SILICON_REVISION};
				endcase
			end
			default: read_byte = 8'h00;
		endcase
	endfunction : read_byte

	function automatic logic [6:0] gap_clocks(input logic [3:0] code);
		return ({3'h0, code} + 7'h01) * eptc_pkg::NONOVL_STEP; // [RL14]
	endfunction : gap_clocks

	function automatic eptc_pkg::eptc_table_t pick_pixel(input logic two_col, input logic [1:0] pol,
			input logic newd, input logic oldd);
		logic [1:0] k;
		k = {newd, oldd} ^ {2{pol[0]}};
		if (!two_col) begin
			// Upper polarity applies to red data, lower to black/white data
			if (newd ^ pol[1]) begin // [RL6] [RL7] [RL8]
				pick_pixel = eptc_pkg::TBL_RED;
			end else begin
				pick_pixel = (oldd ^ pol[0]) ? eptc_pkg::TBL_BLACK : eptc_pkg::TBL_WHITE;
			end
		end else if (!pol[1]) begin
			case (k) // [RL9]
				2'h0: pick_pixel = eptc_pkg::TBL_WHITE_HOLD;
				2'h1: pick_pixel = eptc_pkg::TBL_BLACK_TO_WHITE;
				2'h2: pick_pixel = eptc_pkg::TBL_WHITE_TO_BLACK;
				default: pick_pixel = eptc_pkg::TBL_BLACK_HOLD;
			endcase
		end else begin
			pick_pixel = k[1] ? eptc_pkg::TBL_WHITE_TO_BLACK : eptc_pkg::TBL_BLACK_TO_WHITE; // [RL10]
		end
	endfunction : pick_pixel

	function automatic eptc_pkg::eptc_table_t pick_border(input logic two_col, input logic pol0,
			input logic [1:0] bsel);
		logic [1:0] v;
		v = bsel ^ {2{pol0}};
		case (v)
			2'h1: pick_border = two_col ? eptc_pkg::TBL_BLACK_TO_WHITE : eptc_pkg::TBL_RED; // [RL3] [RL4]
			2'h2: pick_border = two_col ? eptc_pkg::TBL_WHITE_TO_BLACK : eptc_pkg::TBL_WHITE;
			2'h3: pick_border = two_col ? eptc_pkg::TBL_FLOAT : eptc_pkg::TBL_BLACK;
			default: pick_border = eptc_pkg::TBL_FLOAT;
		endcase
	endfunction : pick_border

	eptc_serial_port u_port (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_csb(i_csb),
		.i_scl(i_scl),
		.i_sda_in(i_sda_in),
		.i_dc(i_dc),
		.i_tx_en(s.tx_en),
		.i_tx_load(s.tx_load),
		.i_tx_byte(s.tx_byte),
		.o_rx_valid(rx_valid),
		.o_rx_byte(rx_byte),
		.o_rx_dc(rx_dc),
		.o_sda_out(o_sda_out),
		.o_sda_oe_b(o_sda_oe_b)
	);

	assign flags_byte = {1'b0, i_partial_mode_flag, i_sensor_link_err, i_sensor_link_busy_n, i_frame_received,
		i_power_on_state, i_power_off_state, i_drv_busy_b & (s.sup_st != eptc_pkg::SUP_BUSY)};

	always_comb begin
		n = s;
		busy_now = ~i_drv_busy_b | (s.sup_st == eptc_pkg::SUP_BUSY);
		n.sup_sync = {s.sup_sync[0], i_low_supply_flag};
		n.chk_sync = {s.chk_sync[0], i_panel_check_result};
		n.tx_load = 1'b0;
		case (s.sup_st)
			eptc_pkg::SUP_IDLE: n.sup_cnt = 16'h0000;
			eptc_pkg::SUP_BUSY: begin
				n.sup_cnt = s.sup_cnt + 16'h0001;
				if (s.sup_cnt == 16'(SUP_BUSY_CYC - 1)) begin // [RL12]
					n.sup_st = eptc_pkg::SUP_HOLD;
					n.low_supply = s.sup_sync[1];
					// Refresh a read already waiting on the line
					if (s.cmd_ok && s.cmd == eptc_pkg::CMD_LOW_SUPPLY && s.idx == 2'h0) begin
						n.tx_byte = read_byte(s.cmd, s.idx, n.low_supply, s.panel_ok, flags_byte);
						n.tx_load = 1'b1;
					end
				end
			end
			eptc_pkg::SUP_HOLD: begin
				n.sup_cnt = s.sup_cnt + 16'h0001;
				if (s.sup_cnt == 16'(SUP_WINDOW_CYC - 1)) begin
					n.sup_st = eptc_pkg::SUP_IDLE;
				end
			end
			default: n.sup_st = eptc_pkg::SUP_IDLE;
		endcase
		if (rx_valid) begin
			if (!rx_dc) begin // [RL23]
				n.cmd = rx_byte;
				n.idx = 2'h0;
				// Commands other than the status read are dropped while busy
				n.cmd_ok = (rx_byte == eptc_pkg::CMD_STATUS) || !busy_now; // [RL22] [RL13]
				n.tx_en = n.cmd_ok && is_read(rx_byte);
				n.panel_check_en = n.cmd_ok && rx_byte == eptc_pkg::CMD_PANEL_CHECK;
				if (n.panel_check_en) begin
					n.panel_ok = s.chk_sync[1]; // [RL21]
				end
				if (n.cmd_ok && rx_byte == eptc_pkg::CMD_LOW_SUPPLY && s.sup_st == eptc_pkg::SUP_IDLE) begin
					n.sup_st = eptc_pkg::SUP_BUSY; // [RL12]
					n.sup_cnt = 16'h0000;
				end
			end else if (s.cmd_ok) begin
				case (s.cmd)
					eptc_pkg::CMD_VCOM_INTERVAL: if (s.idx == 2'h0) n.vcom_interval = rx_byte;
					eptc_pkg::CMD_NONOVERLAP: if (s.idx == 2'h0) n.nonoverlap = rx_byte;
					eptc_pkg::CMD_RESOLUTION: begin // [RL15]
						case (s.idx)
							2'h0: n.resolution[23:16] = rx_byte;
							2'h1: n.resolution[15:8] = rx_byte;
							2'h2: n.resolution[7:0] = rx_byte;
							default: ;
						endcase
					end
					eptc_pkg::CMD_START_LINE: begin // [RL17]
						case (s.idx)
							2'h0: n.start_line[23:16] = rx_byte;
							2'h1: n.start_line[15:8] = rx_byte;
							2'h2: n.start_line[7:0] = rx_byte;
							default: ;
						endcase
					end
					default: ;
				endcase
				if (s.idx != 2'h3) begin
					n.idx = s.idx + 2'h1;
				end
			end
			n.tx_byte = read_byte(n.cmd, n.idx, n.low_supply, n.panel_ok, flags_byte); // [RL23]
			n.tx_load = n.tx_en;
		end
		// Settings reach the panel only at a frame boundary
		if (i_frame_start) begin // [RL24]
			n.applied_cfg = s.vcom_interval;
			n.vcom_lines = eptc_pkg::INTERVAL_BASE_LINES - {1'b0, s.vcom_interval[eptc_pkg::INTERVAL_LSB +: 4]}; // [RL1]
			n.front_porch = (i_back_porch_lines > eptc_pkg::BLANKING_LINES) ? 6'h00 :
				eptc_pkg::BLANKING_LINES - i_back_porch_lines; // [RL2]
			n.sgap = gap_clocks(s.nonoverlap[eptc_pkg::SGAP_LSB +: 4]);
			n.ggap = gap_clocks(s.nonoverlap[eptc_pkg::GGAP_LSB +: 4]);
			n.last_src = {s.resolution[eptc_pkg::HRZ_LSB +: 5], 3'h0} - 8'h01; // [RL16]
			n.last_gate = s.resolution[8:0] - 9'h001; // [RL16]
			// Low source bits ignored, host keeps the start on an 8-channel group
			n.first_src = {s.start_line[eptc_pkg::SSTART_LSB +: 5], 3'h0}; // [RL17]
			n.first_gate = s.start_line[8:0];
			n.cascade = s.start_line[eptc_pkg::GSCAN_BIT]; // [RL18]
		end
		n.pixel_valid = i_pixel_valid;
		if (i_pixel_valid) begin
			n.pixel_table = pick_pixel(i_two_colour_select, n.applied_cfg[eptc_pkg::POL_LSB +: 2],
				i_new_frame_data, i_old_frame_data);
		end
		n.border_table = pick_border(i_two_colour_select, n.applied_cfg[eptc_pkg::POL_LSB],
			n.applied_cfg[eptc_pkg::BORDER_LSB +: 2]);
		n.border_level = i_border_level_code; // [RL5]
		n.border_drive = n.border_table != eptc_pkg::TBL_FLOAT;
		n.busy_b = i_drv_busy_b & (n.sup_st != eptc_pkg::SUP_BUSY); // [RL12]
		n.otp_addr = i_otp_bank_sel ? eptc_pkg::OTP_BANK1_REV_ADDR : eptc_pkg::OTP_BANK0_REV_ADDR; // [RL19]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '0;
			s.vcom_interval <= eptc_pkg::VCOM_INTERVAL_RST;
			s.applied_cfg <= eptc_pkg::VCOM_INTERVAL_RST;
			s.nonoverlap <= eptc_pkg::NONOVERLAP_RST;
			s.resolution <= eptc_pkg::RESOLUTION_RST;
			s.start_line <= eptc_pkg::START_LINE_RST;
			s.low_supply <= 1'b1;
			s.busy_b <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign o_busy_b = s.busy_b;
	assign o_pixel_table = s.pixel_table;
	assign o_pixel_table_valid = s.pixel_valid;
	assign o_border_table = s.border_table;
	assign o_border_level = s.border_level;
	assign o_border_drive = s.border_drive;
	assign o_vcom_data_lines = s.vcom_lines;
	assign o_front_porch_lines = s.front_porch;
	assign o_source_to_gate_gap = s.sgap;
	assign o_gate_to_source_gap = s.ggap;
	assign o_first_source = s.first_src;
	assign o_last_source = s.last_src;
	assign o_first_gate = s.first_gate;
	assign o_last_gate = s.last_gate;
	assign o_gate_scan_cascade = s.cascade;
	assign o_panel_check_en = s.panel_check_en;
	assign o_otp_rev_addr = s.otp_addr;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_frame;
		i_frame_start;
	endsequence
	sequence s_sup_start;
		s.sup_st == eptc_pkg::SUP_IDLE ##1 s.sup_st == eptc_pkg::SUP_BUSY;
	endsequence

	property p_vcom_lines;
		s_frame |=> o_vcom_data_lines == eptc_pkg::INTERVAL_BASE_LINES - {1'b0, $past(s.vcom_interval[3:0])};
	endproperty
	a_vcom_lines: assert property (p_vcom_lines) else $error("interval lines wrong"); // [RL1]
	property p_blanking;
		s_frame and i_back_porch_lines <= eptc_pkg::BLANKING_LINES |=>
			6'(o_front_porch_lines + $past(i_back_porch_lines)) == eptc_pkg::BLANKING_LINES;
	endproperty
	a_blanking: assert property (p_blanking) else $error("blanking total not kept"); // [RL2]
	property p_sgap;
		s_frame |=> o_source_to_gate_gap == 7'(({3'h0, $past(s.nonoverlap[7:4])} + 7'h01) * 7'h04);
	endproperty
	a_sgap: assert property (p_sgap) else $error("non-overlap gap wrong"); // [RL14]
	property p_last_gate;
		s_frame |=> o_last_gate == 9'($past(s.resolution[8:0]) - 9'h001);
	endproperty
	a_last_gate: assert property (p_last_gate) else $error("last gate wrong"); // [RL16]
	property p_border_float;
		!i_two_colour_select && s.applied_cfg[7:6] == 2'h3 && s.applied_cfg[4] && !i_frame_start |=>
			o_border_table == eptc_pkg::TBL_FLOAT && !o_border_drive;
	endproperty
	a_border_float: assert property (p_border_float) else $error("border not floating"); // [RL3]
	property p_red_pixel;
		i_pixel_valid && !i_two_colour_select && s.applied_cfg[5:4] == 2'h0 && i_new_frame_data &&
			!i_frame_start |=> o_pixel_table_valid && o_pixel_table == eptc_pkg::TBL_RED;
	endproperty
	a_red_pixel: assert property (p_red_pixel) else $error("red pixel table wrong"); // [RL7]
	property p_sup_busy;
		s_sup_start |-> !o_busy_b [*8];
	endproperty
	a_sup_busy: assert property (p_sup_busy) else $error("busy not held"); // [RL12]
	property p_sup_len;
		s.sup_st == eptc_pkg::SUP_BUSY ##1 s.sup_st == eptc_pkg::SUP_HOLD |-> $past(s.sup_cnt) == 16'(SUP_BUSY_CYC - 1);
	endproperty
	a_sup_len: assert property (p_sup_len) else $error("busy length wrong"); // [RL12]
	property p_lpd_readout;
		s.tx_load && s.cmd == eptc_pkg::CMD_LOW_SUPPLY |-> s.tx_byte[7:1] == 7'h00;
	endproperty
	a_lpd_readout: assert property (p_lpd_readout) else $error("low-supply byte has upper bits"); // [RL11]
	property p_status;
		s.tx_load && s.cmd == eptc_pkg::CMD_STATUS && $past(rx_valid) |->
			s.tx_byte[7] == 1'b0 && s.tx_byte[6] == $past(i_partial_mode_flag);
	endproperty
	a_status: assert property (p_status) else $error("status byte wrong"); // [RL20]
	property p_refuse;
		rx_valid && !rx_dc && busy_now && rx_byte != eptc_pkg::CMD_STATUS |=> !s.cmd_ok ##1 !s.tx_en;
	endproperty
	a_refuse: assert property (p_refuse) else $error("busy command taken"); // [RL22]
endmodule : eptc_panel_timing
`default_nettype wire

// ---- verif/eptc_host_model.sv ----
// Host-side serial master model for the command port
`timescale 1ns/1ps
`default_nettype none
module eptc_host_model (
	input wire logic i_clk,
	input wire logic i_busy_b,
	input wire logic i_sda_wire,
	output logic o_csb,
	output logic o_scl,
	output logic o_sda,
	output logic o_dc
);
	initial begin
		o_csb = 1'b1;
		o_scl = 1'b0;
		o_sda = 1'b0;
		o_dc = 1'b0;
	end
	// Mode 0 at 80 ns; read bits taken just before the fall, while they still stand
	task automatic xbyte(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			// Released line toggles so a stale level never reads as data
			o_sda <= rd ? ~o_sda : tx[i];
			repeat (4) @(posedge i_clk);
			o_scl <= 1'b1;
			repeat (4) @(posedge i_clk);
			rx[i] = i_sda_wire;
			o_scl <= 1'b0;
		end
	endtask : xbyte
	task automatic cmd(input logic [7:0] code);
		logic [7:0] d;
		if (code == eptc_pkg::CMD_PANEL_CHECK || code == eptc_pkg::CMD_LOW_SUPPLY) begin
			for (int n = 0; n < 1000 && i_busy_b !== 1'b1; n++)
				@(posedge i_clk);
		end
		o_csb <= 1'b0;
		o_dc <= 1'b0;
		@(posedge i_clk);
		xbyte(code, 1'b0, d);
		o_dc <= 1'b1;
		repeat (16) @(posedge i_clk);
	endtask : cmd
	task automatic done();
		repeat (4) @(posedge i_clk);
		o_csb <= 1'b1;
		repeat (8) @(posedge i_clk);
	endtask : done
endmodule : eptc_host_model
`default_nettype wire

// ---- verif/test_eptc_panel_timing.sv ----
// Self-checking bench for the panel timing and status block
`timescale 1ns/1ps
`default_nettype none
module test_eptc_panel_timing;
	localparam int BUSY_CYC = 20;
	localparam int WIN_CYC = 60;
	logic clk = 1'b0, rst_b = 1'b0, csb, scl, h_sda, dc, dev_sda, oe_b, busy_b, fs = 1'b0, two = 1'b0, pv = 1'b0;
	logic nd = 1'b0, od = 1'b0, bdrive, ptab_v, gscan, lsf = 1'b1, pcr = 1'b1, pce, bank = 1'b0;
	logic ptl = 1'b0, lerr = 1'b0, lbsy = 1'b1, frx = 1'b0, pwon = 1'b0, pwoff = 1'b0, dbusy = 1'b1;
	logic [1:0] lvl = 2'h0, blvl;
	logic [4:0] vcom;
	logic [5:0] bp = 6'h04, fp;
	logic [6:0] sgap, ggap;
	logic [7:0] fsrc, lsrc, d;
	logic [8:0] fg, lg;
	logic [12:0] otp;
	logic [15:0] wrev = 16'h0000;
	eptc_pkg::eptc_table_t ptab, btab;
	int err_count = 0, total_checks = 0, cyc = 0, low_cnt = 0, c0;
	wire logic sda_wire;
	assign sda_wire = oe_b ? h_sda : dev_sda;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (!busy_b)
			low_cnt <= low_cnt + 1;
		if (cyc == 60000) begin
			err_count++;
			give_verdict();
		end
	end
	eptc_host_model host (.i_clk(clk), .i_busy_b(busy_b), .i_sda_wire(sda_wire), .o_csb(csb), .o_scl(scl),
		.o_sda(h_sda), .o_dc(dc));
	eptc_panel_timing #(.SUP_BUSY_CYC(BUSY_CYC), .SUP_WINDOW_CYC(WIN_CYC)) dut (.i_core_clk(clk), .i_rst_b(rst_b),
		.i_csb(csb), .i_scl(scl), .i_sda_in(sda_wire), .i_dc(dc), .o_sda_out(dev_sda), .o_sda_oe_b(oe_b),
		.o_busy_b(busy_b), .i_frame_start(fs), .i_two_colour_select(two), .i_back_porch_lines(bp),
		.i_pixel_valid(pv), .i_new_frame_data(nd), .i_old_frame_data(od), .o_pixel_table(ptab),
		.o_pixel_table_valid(ptab_v), .i_border_level_code(lvl), .o_border_table(btab), .o_border_level(blvl),
		.o_border_drive(bdrive), .o_vcom_data_lines(vcom), .o_front_porch_lines(fp), .o_source_to_gate_gap(sgap),
		.o_gate_to_source_gap(ggap), .o_first_source(fsrc), .o_last_source(lsrc), .o_first_gate(fg),
		.o_last_gate(lg), .o_gate_scan_cascade(gscan), .i_low_supply_flag(lsf), .i_panel_check_result(pcr),
		.o_panel_check_en(pce), .i_otp_bank_sel(bank), .o_otp_rev_addr(otp), .i_waveform_table_revision(wrev),
		.i_partial_mode_flag(ptl), .i_sensor_link_err(lerr), .i_sensor_link_busy_n(lbsy),
		.i_frame_received(frx), .i_power_on_state(pwon), .i_power_off_state(pwoff), .i_drv_busy_b(dbusy));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (exp !== got) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] code, input logic [23:0] v, input int n);
		logic [7:0] r;
		host.cmd(code);
		for (int i = 0; i < n; i++)
			host.xbyte(v[23 - 8 * i -: 8], 1'b0, r);
		host.done();
	endtask : wr
	task automatic rd(input logic [7:0] code, output logic [7:0] r);
		host.cmd(code);
		host.xbyte(8'h00, 1'b1, r);
		host.done();
	endtask : rd
	task automatic apply_frame();
		@(posedge clk) fs <= 1'b1;
		@(posedge clk) fs <= 1'b0;
		@(posedge clk);
		#1;
	endtask : apply_frame
	function automatic eptc_pkg::eptc_table_t exp_pix(logic tw, logic [1:0] p, logic n, logic o);
		logic [1:0] v;
		v = {n, o} ^ {2{p[0]}};
		if (!tw)
			return (n != p[1]) ? eptc_pkg::TBL_RED : (o == p[0]) ? eptc_pkg::TBL_WHITE : eptc_pkg::TBL_BLACK;
		if (p[1])
			return (n ^ p[0]) ? eptc_pkg::TBL_WHITE_TO_BLACK : eptc_pkg::TBL_BLACK_TO_WHITE;
		return v == 2'b00 ? eptc_pkg::TBL_WHITE_HOLD : v == 2'b01 ? eptc_pkg::TBL_BLACK_TO_WHITE :
			v == 2'b10 ? eptc_pkg::TBL_WHITE_TO_BLACK : eptc_pkg::TBL_BLACK_HOLD;
	endfunction : exp_pix
	function automatic eptc_pkg::eptc_table_t exp_bdr(logic tw, logic p0, logic [1:0] vb);
		if (!tw)
			return eptc_pkg::eptc_table_t'({1'b0, vb ^ {2{p0}}});
		if (vb == 2'b00 || vb == 2'b11)
			return eptc_pkg::TBL_FLOAT;
		return (vb[0] ^ p0) ? eptc_pkg::TBL_BLACK_TO_WHITE : eptc_pkg::TBL_WHITE_TO_BLACK;
	endfunction : exp_bdr
	initial begin
		logic [7:0] c, t;
		logic [4:0] h, s;
		logic [8:0] v, g;
		logic gs;
		void'($urandom(32'hb87d));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk("busy_b", 16'h1, busy_b);
		apply_frame();
		chk("vcom_dflt", 16'd10, vcom);
		chk("sgap_dflt", 16'd12, sgap);
		chk("fp_dflt", 16'd16, fp);
		for (int k = 0; k < 4; k++) begin
			c = 8'($urandom);
			t = 8'($urandom);
			h = 5'($urandom_range(31, 1));
			v = 9'($urandom_range(296, 1));
			s = 5'($urandom);
			g = 9'($urandom);
			gs = 1'($urandom);
			@(posedge clk) bp <= 6'($urandom_range(20, 0));
			wr(eptc_pkg::CMD_VCOM_INTERVAL, {c, 16'h0}, 1);
			wr(eptc_pkg::CMD_NONOVERLAP, {t, 16'h0}, 1);
			wr(eptc_pkg::CMD_RESOLUTION, {h, 3'h0, 7'h0, v}, 3);
			wr(eptc_pkg::CMD_START_LINE, {s, 3'h0, 3'h0, gs, 3'h0, g}, 3);
			apply_frame();
			chk("vcom", 16'(5'd17 - 5'(c[3:0])), vcom);
			chk("fp", 16'(6'd20 - bp), fp);
			chk("sgap", 16'(4 * t[7:4] + 4), sgap);
			chk("ggap", 16'(4 * t[3:0] + 4), ggap);
			chk("lsrc", 16'(8'(h * 8 - 1)), lsrc);
			chk("lgate", 16'(v - 9'd1), lg);
			chk("fsrc", 16'(s * 8), fsrc);
			chk("fgate", 16'(g), fg);
			chk("gscan", 16'(gs), gscan);
		end
		@(posedge clk) dbusy <= 1'b0;
		wr(eptc_pkg::CMD_NONOVERLAP, {~t, 16'h0}, 1);
		@(posedge clk) {ptl, lerr, lbsy, frx, pwon, pwoff} <= 6'($urandom);
		rd(eptc_pkg::CMD_STATUS, d);
		chk("status", 16'({1'b0, ptl, lerr, lbsy, frx, pwon, pwoff, dbusy}), d);
		@(posedge clk) dbusy <= 1'b1;
		apply_frame();
		chk("sgap_kept", 16'(4 * t[7:4] + 4), sgap);
		for (int k = 0; k < 32; k++) begin
			@(posedge clk) two <= k[4];
			wr(eptc_pkg::CMD_VCOM_INTERVAL, {k[1:0], k[3:2], 4'h0, 16'h0}, 1);
			apply_frame();
			chk("btab", 16'(exp_bdr(k[4], k[2], k[1:0])), btab);
			chk("bdrive", 16'(exp_bdr(k[4], k[2], k[1:0]) != eptc_pkg::TBL_FLOAT), bdrive);
			@(posedge clk) lvl <= 2'(k + $urandom);
			@(posedge clk);
			#1;
			chk("blvl", 16'(lvl), blvl);
			for (int m = 0; m < 4; m++) begin
				@(posedge clk) {pv, nd, od} <= {1'b1, 2'(m)};
				@(posedge clk) pv <= 1'b0;
				#1;
				chk("ptab_v", 16'h1, ptab_v);
				chk("ptab", 16'(exp_pix(k[4], k[3:2], m[1], m[0])), ptab);
			end
		end
		@(posedge clk) {bank, wrev} <= 17'($urandom);
		host.cmd(eptc_pkg::CMD_REVISION);
		chk("otp", bank ? eptc_pkg::OTP_BANK1_REV_ADDR : eptc_pkg::OTP_BANK0_REV_ADDR, otp);
		host.xbyte(8'h00, 1'b1, d);
		chk("rev_lo", 16'(wrev[7:0]), d);
		host.xbyte(8'h00, 1'b1, d);
		chk("rev_hi", 16'(wrev[15:8]), d);
		host.xbyte(8'h00, 1'b1, d);
		chk("ident", 16'({eptc_pkg::VENDOR_CODE, eptc_pkg::SILICON_REVISION}), d);
		host.done();
		for (int r = 0; r < 2; r++) begin
			@(posedge clk) {pcr, lsf} <= {1'(r), 1'(r)};
			host.cmd(eptc_pkg::CMD_PANEL_CHECK);
			chk("pce", 16'h1, pce);
			host.xbyte(8'h00, 1'b1, d);
			host.done();
			chk("pcheck", 16'(r), d[0]);
			repeat (WIN_CYC) @(posedge clk);
			c0 = low_cnt;
			host.cmd(eptc_pkg::CMD_LOW_SUPPLY);
			for (int n = 0; n < 200 && busy_b !== 1'b1; n++)
				@(posedge clk);
			@(posedge clk);
			chk("busy_len", 16'(BUSY_CYC), 16'(low_cnt - c0));
			host.xbyte(8'h00, 1'b1, d);
			host.done();
			chk("lowsup", 16'(r), d[0]);
		end
		give_verdict();
	end
endmodule : test_eptc_panel_timing
`default_nettype wire
